// ---- design/bdms_pkg.sv ----
// Constants and types shared by the banked data memory and status block
`default_nettype none
package bdms_pkg;
    // Address geometry
    localparam int          NUM_BANKS     = 32;
    localparam int          BANK_BYTES    = 128;
    localparam int          DADDR_W       = 12;
    localparam int          BANK_W        = 5;
    localparam int          OFFS_W        = 7;
    // In-bank region limits
    localparam logic [6:0]  OFF_IND0      = 7'h00;
    localparam logic [6:0]  OFF_IND1      = 7'h01;
    localparam logic [6:0]  OFF_PERI_LO   = 7'h0c;
    localparam logic [6:0]  OFF_GPR_LO    = 7'h20;
    localparam logic [6:0]  OFF_COM_LO    = 7'h70;
    // Core register offsets
    localparam logic [3:0]  CR_PC_LOW     = 4'h2;
    localparam logic [3:0]  CR_STATUS     = 4'h3;
    localparam logic [3:0]  CR_PTR0_LOW   = 4'h4;
    localparam logic [3:0]  CR_PTR0_HIGH  = 4'h5;
    localparam logic [3:0]  CR_PTR1_LOW   = 4'h6;
    localparam logic [3:0]  CR_PTR1_HIGH  = 4'h7;
    localparam logic [3:0]  CR_BANK_SEL   = 4'h8;
    localparam logic [3:0]  CR_WORKING    = 4'h9;
    localparam logic [3:0]  CR_PC_HIGH    = 4'ha;
    localparam logic [3:0]  CR_INT_CTRL   = 4'hb;
    // General RAM sizing: banks that carry RAM, bytes per bank
    localparam logic [4:0]  GPR_BANKS     = 5'h04;
    localparam logic [8:0]  GPR_PER_BANK  = 9'h050;
    localparam int          GPR_BYTES     = 320;
    localparam logic [12:0] GPR_LIN_LIMIT = 13'h0140;
    localparam int          COM_BYTES     = 16;
    // Pointer windows: linear RAM and program memory
    localparam logic [2:0]  PTR_LIN_TAG   = 3'b001;
    // Status field positions and reset values
    localparam int          ST_TO         = 4;
    localparam int          ST_PD         = 3;
    localparam int          ST_Z          = 2;
    localparam int          ST_DC         = 1;
    localparam int          ST_C          = 0;
    localparam logic [7:0]  STATUS_RST    = 8'h18;
    localparam logic [7:0]  STATUS_IMPL   = 8'h1f;
    localparam logic [7:0]  REG_RST       = 8'h00;
    // Flag-producing operation presented with an access
    typedef enum logic [2:0] {
        ALU_NONE,
        ALU_LOGIC,
        ALU_ADD,
        ALU_SUB,
        ALU_RRF,
        ALU_RLF
    } bdms_aluop_e;
endpackage : bdms_pkg
`default_nettype wire

// ---- design/bdms_top.sv ----
// Banked data memory decode, core registers and status register
`default_nettype none
module bdms_top
    import bdms_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [6:0]        acc_offset,
    input  wire logic              acc_rd,
    input  wire logic              acc_wr,
    input  wire logic [7:0]        acc_wdata,
    input  wire bdms_pkg::bdms_aluop_e alu_op,
    input  wire logic [7:0]        alu_a,
    input  wire logic [7:0]        alu_b,
    input  wire logic              wdt_clear_op,
    input  wire logic              sleep_op,
    input  wire logic              wdt_timeout,
    output logic [7:0]             rdata_r,
    output logic [7:0]             alu_result_r,
    output logic [7:0]             status_r,
    output logic [7:0]             bank_select_r,
    output logic [7:0]             working_reg_r,
    output logic [7:0]             pc_low_r,
    output logic [7:0]             pc_high_latch_r,
    output logic [7:0]             interrupt_control_r,
    output logic [7:0]             pointer0_low_r,
    output logic [7:0]             pointer0_high_r,
    output logic [7:0]             pointer1_low_r,
    output logic [7:0]             pointer1_high_r
);
    import bdms_pkg::*;

    // Storage for general and common RAM
    logic [7:0]         gpr_mem_r [GPR_BYTES];
    logic [7:0]         com_mem_r [COM_BYTES];

    // Resolved access
    logic [15:0]        ptr_sel;
    logic               is_ind;
    logic               valid;
    logic               lin;
    logic [12:0]        lin_idx;
    logic [DADDR_W-1:0] daddr;
    logic [OFFS_W-1:0]  off;
    logic [BANK_W-1:0]  bank;
    logic               hit_core;
    logic               hit_gpr;
    logic               hit_com;
    logic [3:0]         core_sel;
    logic [8:0]         gpr_idx;
    logic [3:0]         com_idx;
    logic               wr_core;

    // Address resolution: direct, indirect data, linear RAM
    always_comb
    begin
        is_ind  = (acc_offset == OFF_IND0) || (acc_offset == OFF_IND1);
        ptr_sel = (acc_offset == OFF_IND1) ? {pointer1_high_r, pointer1_low_r}
                                           : {pointer0_high_r, pointer0_low_r};
        valid   = 1'b1;
        lin     = 1'b0;
        lin_idx = ptr_sel[12:0];
        daddr   = {bank_select_r[BANK_W-1:0], acc_offset};
        if (is_ind)
        begin
            if (ptr_sel[15])
            begin
                valid = 1'b0;                                 // Program memory, not here
            end
            else if (ptr_sel[15:13] == PTR_LIN_TAG)
            begin
                lin   = 1'b1;
                valid = lin_idx < GPR_LIN_LIMIT;
            end
            else
            begin
                daddr = ptr_sel[DADDR_W-1:0];
            end
        end
    end

    // Region decode within the 128-byte bank
    always_comb
    begin
        off      = daddr[OFFS_W-1:0];
        bank     = daddr[DADDR_W-1:OFFS_W];
        core_sel = off[3:0];
        com_idx  = off[3:0];
        hit_core = valid && !lin && (off < OFF_PERI_LO);
        hit_com  = valid && !lin && (off >= OFF_COM_LO);
        if (lin)
        begin
            hit_gpr = valid;
            gpr_idx = lin_idx[8:0];
        end
        else
        begin
            hit_gpr = valid && (off >= OFF_GPR_LO) && (off < OFF_COM_LO)
                      && (bank < GPR_BANKS);
            gpr_idx = 9'(bank) * GPR_PER_BANK + 9'(off) - 9'(OFF_GPR_LO);
        end
        // Indirect ports seen through a pointer hold no data
        wr_core = acc_wr && hit_core;
    end

    // Flag computation
    logic [7:0] op2;
    logic       cin;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [2:0] fl_upd;
    logic [2:0] fl_val;
    always_comb
    begin
        op2    = (alu_op == ALU_SUB) ? ~alu_b : alu_b;
        cin    = (alu_op == ALU_SUB);
        sum9   = {1'b0, alu_a} + {1'b0, op2} + {8'h00, cin};
        nib5   = {1'b0, alu_a[3:0]} + {1'b0, op2[3:0]} + {4'h0, cin};
        fl_upd = 3'b000;
        fl_val = 3'b000;
        unique case (alu_op)
            ALU_NONE:
            begin
                fl_upd = 3'b000;
            end
            ALU_LOGIC:
            begin
                fl_upd = 3'b100;
                fl_val = {alu_a == 8'h00, 2'b00};
            end
            ALU_ADD, ALU_SUB:
            begin
                fl_upd = 3'b111;
                fl_val = {sum9[7:0] == 8'h00, nib5[4], sum9[8]};
            end
            ALU_RRF:
            begin
                fl_upd = 3'b001;
                fl_val = {2'b00, alu_a[0]};
            end
            ALU_RLF:
            begin
                fl_upd = 3'b001;
                fl_val = {2'b00, alu_a[7]};
            end
            default:
            begin
                fl_upd = 3'b000;
            end
        endcase
    end

    // Adder result for the core
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            alu_result_r <= REG_RST;
        else if (alu_op == ALU_ADD || alu_op == ALU_SUB)
            alu_result_r <= sum9[7:0];
    end

    // Status register: protected write, flag update, reset cause
    logic [7:0] status_nxt;
    always_comb
    begin
        status_nxt = status_r;
        // Any flag op in the same cycle drops the whole write to Z, DC and C
        if (wr_core && core_sel == CR_STATUS && fl_upd == 3'b000)
            status_nxt[2:0] = acc_wdata[2:0];
        for (int i = 0; i < 3; i++)
            if (fl_upd[i])
                status_nxt[i] = fl_val[i];
        if (wdt_clear_op)
        begin
            status_nxt[ST_TO] = 1'b1;
            status_nxt[ST_PD] = 1'b1;
        end
        if (sleep_op)
        begin
            status_nxt[ST_TO] = 1'b1;
            status_nxt[ST_PD] = 1'b0;
        end
        if (wdt_timeout)
            status_nxt[ST_TO] = 1'b0;
        status_nxt = status_nxt & STATUS_IMPL;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status_r <= STATUS_RST;
        else
            status_r <= status_nxt;
    end

    // Plain core registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bank_select_r       <= REG_RST;
            working_reg_r       <= REG_RST;
            pc_low_r            <= REG_RST;
            pc_high_latch_r     <= REG_RST;
            interrupt_control_r <= REG_RST;
            pointer0_low_r      <= REG_RST;
            pointer0_high_r     <= REG_RST;
            pointer1_low_r      <= REG_RST;
            pointer1_high_r     <= REG_RST;
        end
        else if (wr_core)
        begin
            unique case (core_sel)
                CR_BANK_SEL:  bank_select_r       <= acc_wdata;
                CR_WORKING:   working_reg_r       <= acc_wdata;
                CR_PC_LOW:    pc_low_r            <= acc_wdata;
                CR_PC_HIGH:   pc_high_latch_r     <= acc_wdata;
                CR_INT_CTRL:  interrupt_control_r <= acc_wdata;
                CR_PTR0_LOW:  pointer0_low_r      <= acc_wdata;
                CR_PTR0_HIGH: pointer0_high_r     <= acc_wdata;
                CR_PTR1_LOW:  pointer1_low_r      <= acc_wdata;
                CR_PTR1_HIGH: pointer1_high_r     <= acc_wdata;
                default:      ;                               // Status and ports elsewhere
            endcase
        end
    end

    // General and common RAM writes
    always_ff @(posedge clk)
    begin
        if (acc_wr && hit_gpr)
            gpr_mem_r[gpr_idx] <= acc_wdata;
        if (acc_wr && hit_com)
            com_mem_r[com_idx] <= acc_wdata;
    end

    // Read mux; peripheral space and holes give zero
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        if (hit_gpr)
            rd_mux = gpr_mem_r[gpr_idx];
        else if (hit_com)
            rd_mux = com_mem_r[com_idx];
        else if (hit_core)
        begin
            unique case (core_sel)
                CR_PC_LOW:    rd_mux = pc_low_r;
                CR_STATUS:    rd_mux = status_r;
                CR_PTR0_LOW:  rd_mux = pointer0_low_r;
                CR_PTR0_HIGH: rd_mux = pointer0_high_r;
                CR_PTR1_LOW:  rd_mux = pointer1_low_r;
                CR_PTR1_HIGH: rd_mux = pointer1_high_r;
                CR_BANK_SEL:  rd_mux = bank_select_r;
                CR_WORKING:   rd_mux = working_reg_r;
                CR_PC_HIGH:   rd_mux = pc_high_latch_r;
                CR_INT_CTRL:  rd_mux = interrupt_control_r;
                default:      rd_mux = 8'h00;                 // Ports through a pointer
            endcase
        end
    end

    // Registered read data, one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata_r <= REG_RST;
        else if (acc_rd)
            rdata_r <= rd_mux;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_status_upper_zero: assert property (status_r[7:5] == 3'b000)
        else $error("status upper bits not zero");
    a_reset_flags_init: assert property (disable iff (1'b0)
        !rst_n |=> status_r == STATUS_RST)
        else $error("status reset value wrong");
    a_sw_keeps_rst: assert property (
        acc_wr && !is_ind && acc_offset == 7'(CR_STATUS) && !wdt_clear_op && !sleep_op
        && !wdt_timeout |=> $stable(status_r[4:3]))
        else $error("software changed reset flags");
    a_add_carry_out: assert property (
        alu_op == ALU_ADD
        |=> status_r[0] == ((9'($past(alu_a)) + 9'($past(alu_b))) > 9'h0ff))
        else $error("add carry wrong");
    a_sub_borrow_low: assert property (
        alu_op == ALU_SUB && alu_a < alu_b |=> !status_r[0])
        else $error("borrow polarity wrong");
    a_add_digit_carry: assert property (
        alu_op == ALU_ADD && (5'(alu_a[3:0]) + 5'(alu_b[3:0])) > 5'h0f |=> status_r[1])
        else $error("digit carry not set");
    a_logic_zero_flag: assert property (
        alu_op == ALU_LOGIC |=> status_r[2] == ($past(alu_a) == 8'h00))
        else $error("zero flag wrong");
    a_rotate_right_c: assert property (
        alu_op == ALU_RRF |=> status_r[0] == $past(alu_a[0]))
        else $error("rotate carry wrong");
    a_status_wr_guard: assert property (
        acc_wr && hit_core && core_sel == CR_STATUS && alu_op == ALU_ADD
        |=> status_r[0] == ((9'($past(alu_a)) + 9'($past(alu_b))) > 9'h0ff)
        && status_r[2] == ((8'($past(alu_a)) + 8'($past(alu_b))) == 8'h00))
        else $error("status write overrode flags");
    a_sleep_sets_flags: assert property (
        sleep_op && !wdt_timeout |=> status_r[4:3] == 2'b10)
        else $error("sleep flags wrong");
    a_wdt_timeout_clr: assert property (wdt_timeout |=> !status_r[ST_TO])
        else $error("timeout did not clear flag");
    a_bank_sel_load: assert property (
        acc_wr && acc_offset == 7'(CR_BANK_SEL) |=> bank_select_r == $past(acc_wdata))
        else $error("bank select not loaded");
    a_peri_read_zero: assert property (
        acc_rd && !is_ind && acc_offset >= OFF_PERI_LO && acc_offset < OFF_GPR_LO
        |=> rdata_r == 8'h00)
        else $error("peripheral space not zero");
    a_core_mirror_rd: assert property (
        acc_rd && acc_offset == 7'(CR_WORKING) && !acc_wr
        |=> rdata_r == working_reg_r)
        else $error("core mirror read wrong");
    // Status write beside a rotate keeps Z and DC, takes only the rotated carry
    a_status_wr_drop: assert property (
        wr_core && core_sel == CR_STATUS && alu_op == ALU_RRF
        |=> status_r[2:1] == $past(status_r[2:1]) && status_r[0] == $past(alu_a[0]))
        else $error("status write not dropped");
    a_rotate_left_c: assert property (
        alu_op == ALU_RLF |=> status_r[0] == $past(alu_a[7]))
        else $error("rotate left carry wrong");
    a_clear_sets_flags: assert property (
        wdt_clear_op && !sleep_op && !wdt_timeout |=> status_r[4:3] == 2'b11)
        else $error("watchdog clear flags wrong");
    a_sleep_clears_pd: assert property (sleep_op |=> !status_r[ST_PD])
        else $error("sleep did not clear flag");
    a_sub_digit_borrow: assert property (
        alu_op == ALU_SUB && alu_a[3:0] < alu_b[3:0] |=> !status_r[1])
        else $error("digit borrow polarity wrong");
    a_sub_result: assert property (
        alu_op == ALU_SUB |=> alu_result_r == 8'($past(alu_a) - $past(alu_b)))
        else $error("subtract result wrong");
    a_linear_oob_zero: assert property (
        acc_rd && lin && !valid |=> rdata_r == 8'h00)
        else $error("linear read past end not zero");

    c_common_write: cover property (acc_wr && hit_com ##1 acc_rd && hit_com);
    c_linear_access: cover property (acc_rd && lin && valid);
    c_sub_no_borrow: cover property (alu_op == ALU_SUB && alu_a >= alu_b);
    c_status_protect: cover property (wr_core && core_sel == CR_STATUS && fl_upd != 3'b000);
endmodule : bdms_top
`default_nettype wire

// ---- bench/bdms_cpu_model.sv ----
// CPU-side model: drives access, flag and event ports one instruction cycle at a time
`default_nettype none
module bdms_cpu_model
    import bdms_pkg::*;
(
    input  wire logic              clk,
    output logic [6:0]             acc_offset,
    output logic                   acc_rd,
    output logic                   acc_wr,
    output logic [7:0]             acc_wdata,
    output var bdms_pkg::bdms_aluop_e alu_op,
    output logic [7:0]             alu_a,
    output logic [7:0]             alu_b,
    output logic                   wdt_clear_op,
    output logic                   sleep_op,
    output logic                   wdt_timeout
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet bus at time zero
    initial
    begin
        {acc_offset, acc_rd, acc_wr, acc_wdata} = '0;
        {alu_a, alu_b, wdt_clear_op, sleep_op, wdt_timeout} = '0;
        alu_op = ALU_NONE;
    end

    // One cycle: drive just after an edge, hold through the next edge
    // Status writes take effect only when no flag op is presented alongside
    task automatic cyc(input logic rd, input logic wr, input logic [6:0] off,
                       input logic [7:0] wd, input bdms_aluop_e op,
                       input logic [7:0] a, input logic [7:0] b, input logic [2:0] ev);
        acc_rd = rd;
        acc_wr = wr;
        acc_offset = off;
        acc_wdata = wr ? wd : ~acc_wdata;   // Unused data lines do not keep stale value
        alu_op = op;
        alu_a = (op == ALU_NONE) ? ~alu_a : a;
        alu_b = (op == ALU_NONE) ? ~alu_b : b;
        {wdt_timeout, sleep_op, wdt_clear_op} = ev;
        @(posedge clk);
        #1;
    endtask : cyc
endmodule : bdms_cpu_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the banked data memory and status block
`default_nettype none
module tb;
    import bdms_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst_n;
    logic [6:0]  acc_offset;
    logic        acc_rd;
    logic        acc_wr;
    logic [7:0]  acc_wdata;
    bdms_aluop_e alu_op;
    logic [7:0]  alu_a;
    logic [7:0]  alu_b;
    logic        wdt_clear_op;
    logic        sleep_op;
    logic        wdt_timeout;
    logic [7:0]  rdata_r;
    logic [7:0]  alu_result_r;
    logic [7:0]  status_r;
    logic [7:0]  bank_select_r;
    logic [7:0]  working_reg_r;
    logic [7:0]  pc_low_r;
    logic [7:0]  pc_high_latch_r;
    logic [7:0]  interrupt_control_r;
    logic [7:0]  pointer0_low_r;
    logic [7:0]  pointer0_high_r;
    logic [7:0]  pointer1_low_r;
    logic [7:0]  pointer1_high_r;
    int          num_errors;
    int          comparisons;
    // Flag sequence: operation, operands, expected low status bits, sum
    bdms_aluop_e ops [8] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB,
                             ALU_LOGIC, ALU_RLF, ALU_RRF, ALU_LOGIC};
    logic [7:0]  va [8]  = '{8'h0f, 8'hff, 8'h03, 8'h05, 8'h05, 8'h7f, 8'h01, 8'h00};
    logic [7:0]  vb [8]  = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0]  vf [8]  = '{3'h2, 3'h7, 3'h0, 3'h7, 3'h3, 3'h2, 3'h3, 3'h7};
    logic [7:0]  vr [4]  = '{8'h10, 8'h00, 8'hfe, 8'h00};

    bdms_top dut (.clk(clk), .rst_n(rst_n), .acc_offset(acc_offset), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata), .alu_op(alu_op), .alu_a(alu_a),
        .alu_b(alu_b), .wdt_clear_op(wdt_clear_op), .sleep_op(sleep_op),
        .wdt_timeout(wdt_timeout), .rdata_r(rdata_r), .alu_result_r(alu_result_r),
        .status_r(status_r), .bank_select_r(bank_select_r),
        .working_reg_r(working_reg_r), .pc_low_r(pc_low_r),
        .pc_high_latch_r(pc_high_latch_r), .interrupt_control_r(interrupt_control_r),
        .pointer0_low_r(pointer0_low_r), .pointer0_high_r(pointer0_high_r),
        .pointer1_low_r(pointer1_low_r), .pointer1_high_r(pointer1_high_r));

    bdms_cpu_model cpu (.clk(clk), .acc_offset(acc_offset), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata), .alu_op(alu_op), .alu_a(alu_a),
        .alu_b(alu_b), .wdt_clear_op(wdt_clear_op), .sleep_op(sleep_op),
        .wdt_timeout(wdt_timeout));

    // 100 ns core clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [6:0] off, input logic [7:0] d);
        cpu.cyc(1'b0, 1'b1, off, d, ALU_NONE, 8'h00, 8'h00, 3'h0);
    endtask : wr

    // Read and compare one cycle later
    task automatic rdchk(input logic [6:0] off, input logic [7:0] exp);
        cpu.cyc(1'b1, 1'b0, off, 8'h00, ALU_NONE, 8'h00, 8'h00, 3'h0);
        chk("rdata_r", exp, rdata_r);
    endtask : rdchk

    // Reset or processor event, then status compare
    task automatic evchk(input logic [2:0] ev, input logic [7:0] exp);
        cpu.cyc(1'b0, 1'b0, 7'h00, 8'h00, ALU_NONE, 8'h00, 8'h00, ev);
        chk("status_r", exp, status_r);
    endtask : evchk

    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Hang guard, far beyond the fewer than one hundred cycles of the sequence
    initial
    begin
        #100us;
        num_errors++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        evchk(3'h0, 8'h18);
        chk("bank_select_r", 8'h00, bank_select_r);
        for (int i = 0; i < 8; i++)
        begin
            cpu.cyc(1'b0, 1'b0, 7'h00, 8'h00, ops[i], va[i], vb[i], 3'h0);
            chk("status_r", {5'h03, vf[i]}, status_r);
            if (i < 4)
                chk("alu_result_r", vr[i], alu_result_r);
        end
        // Core registers, later ones through the bank picked by offset 8
        for (int o = 2; o < 12; o++)
        begin
            if (o == 3)
                continue;
            wr(7'(o), 8'h40 + 8'(o));
            rdchk(7'(o), 8'h40 + 8'(o));
        end
        chk("bank_select_r", 8'h48, bank_select_r);
        chk("pointer1_high_r", 8'h47, pointer1_high_r);
        chk("interrupt_control_r", 8'h4b, interrupt_control_r);
        chk("pc_low_r", 8'h42, pc_low_r);
        chk("working_reg_r", 8'h49, working_reg_r);
        chk("pc_high_latch_r", 8'h4a, pc_high_latch_r);
        chk("pointer0_low_r", 8'h44, pointer0_low_r);
        chk("pointer0_high_r", 8'h45, pointer0_high_r);
        chk("pointer1_low_r", 8'h46, pointer1_low_r);
        wr(7'h08, 8'h02);
        wr(7'h75, 8'ha5);
        wr(7'h08, 8'h07);
        rdchk(7'h75, 8'ha5);
        wr(7'h08, 8'h01);
        wr(7'h20, 8'h11);
        wr(7'h08, 8'h00);
        wr(7'h20, 8'h22);
        wr(7'h6f, 8'h66);
        rdchk(7'h6f, 8'h66);
        wr(7'h08, 8'h01);
        rdchk(7'h20, 8'h11);
        wr(7'h0c, 8'hff);
        rdchk(7'h0c, 8'h00);
        wr(7'h08, 8'h09);
        wr(7'h30, 8'h5a);
        rdchk(7'h30, 8'h00);
        wr(7'h08, 8'h1f);
        rdchk(7'h75, 8'ha5);
        // Indirect and linear accesses
        wr(7'h04, 8'h50);
        wr(7'h05, 8'h20);
        rdchk(7'h00, 8'h11);
        wr(7'h06, 8'h20);
        wr(7'h07, 8'h00);
        wr(7'h01, 8'h33);
        wr(7'h08, 8'h00);
        rdchk(7'h20, 8'h33);
        wr(7'h04, 8'h75);
        wr(7'h05, 8'h0f);
        rdchk(7'h00, 8'ha5);
        wr(7'h04, 8'h40);
        wr(7'h05, 8'h21);
        rdchk(7'h00, 8'h00);
        // Status writes against flag updates
        wr(7'h03, 8'hff);
        chk("status_r", 8'h1f, status_r);
        wr(7'h03, 8'h00);
        chk("status_r", 8'h18, status_r);
        cpu.cyc(1'b0, 1'b1, 7'h03, 8'h07, ALU_ADD, 8'h0f, 8'h01, 3'h0);
        chk("status_r", 8'h1a, status_r);
        rdchk(7'h03, 8'h1a);
        evchk(3'h2, 8'h12);
        evchk(3'h4, 8'h02);
        evchk(3'h1, 8'h1a);
        evchk(3'h4, 8'h0a);
        // Reset in mid-run
        rst_n = 1'b0;
        evchk(3'h0, 8'h18);
        rst_n = 1'b1;
        chk("bank_select_r", 8'h00, bank_select_r);
        // Status write beside a rotate: only the carry moves
        cpu.cyc(1'b0, 1'b1, 7'h03, 8'h07, ALU_RRF, 8'h01, 8'h00, 3'h0);
        chk("status_r", 8'h19, status_r);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
